// File: verilog/acrc_core.sv
`timescale 1ns/1ps
module acrc_core (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rstn,
	// host strobes
	input  wire logic                         conversion_start_n,
	input  wire logic                         select_n,
	input  wire logic                         read_n,
	// converter result
	input  wire logic [acrc_pkg::DATA_W-1:0]  result,
	// status and data pins
	output logic                              busy,
	output logic                              sampling,
	output logic                              trim_loading,
	output logic                              trim_done,
	output logic [acrc_pkg::DATA_W-1:0]       data_out,
	output logic [acrc_pkg::DATA_W-1:0]       data_oe
);
	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic start_s;
	logic sel_s;
	logic rd_s;
	logic start_p_q;
	logic sel_p_q;

	acrc_sync u_sync_start (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (conversion_start_n),
		.level (start_s)
	);
	acrc_sync u_sync_sel (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (select_n),
		.level (sel_s)
	);
	acrc_sync u_sync_rd (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (read_n),
		.level (rd_s)
	);

	wire start_fall = start_p_q & ~start_s;
	wire sel_fall   = sel_p_q & ~sel_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			start_p_q <= 1'b1;
			sel_p_q   <= 1'b1;
		end else begin
			start_p_q <= start_s;
			sel_p_q   <= sel_s;
		end
	end

	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	acrc_pkg::acrc_state_t state_q;
	acrc_pkg::acrc_state_t state_d;
	logic [acrc_pkg::CNT_W-1:0] cnt_q;
	logic [acrc_pkg::CNT_W-1:0] cnt_d;
	logic [1:0]                 trims_q;
	logic [acrc_pkg::DATA_W-1:0] latch_q;

	wire in_conv   = (state_q == acrc_pkg::ACRC_CONV);
	// a start fall needs select low; only an idle device converts
	wire go_conv   = (state_q == acrc_pkg::ACRC_IDLE) & start_fall & ~sel_s;
	wire abort_req = in_conv & ((start_fall & ~sel_s) | sel_fall);
	wire conv_end  = in_conv & ~abort_req
		& (cnt_q == acrc_pkg::CNT_W'(acrc_pkg::CONV_CYCLES - 1));
	wire por_end   = (state_q == acrc_pkg::ACRC_POR)
		& (cnt_q == acrc_pkg::CNT_W'(acrc_pkg::POR_CYCLES - 1));
	wire trim_act  = trims_q != acrc_pkg::TRIM_CONVS;
	// busy falls on conversion end or on internal reset; either opens sampling while select is low
	wire busy_fall = conv_end | (state_q == acrc_pkg::ACRC_RESET);

	// next state and counter
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + acrc_pkg::CNT_W'(1);
		case (state_q)
			acrc_pkg::ACRC_POR: begin
				if (por_end) begin
					state_d = acrc_pkg::ACRC_IDLE;
					cnt_d   = acrc_pkg::CNT_IDLE;
				end
			end
			acrc_pkg::ACRC_IDLE: begin
				cnt_d = acrc_pkg::CNT_IDLE;
				if (go_conv) begin
					state_d = acrc_pkg::ACRC_CONV;
				end
			end
			acrc_pkg::ACRC_CONV: begin
				if (abort_req) begin
					state_d = acrc_pkg::ACRC_RESET;
					cnt_d   = acrc_pkg::CNT_IDLE;
				end else if (conv_end) begin
					state_d = acrc_pkg::ACRC_IDLE;
					cnt_d   = acrc_pkg::CNT_IDLE;
				end
			end
			acrc_pkg::ACRC_RESET: begin
				// self-clearing: one cycle, no host release needed
				state_d = acrc_pkg::ACRC_IDLE;
				cnt_d   = acrc_pkg::CNT_IDLE;
			end
			default: begin
				state_d = acrc_pkg::ACRC_IDLE;
				cnt_d   = acrc_pkg::CNT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= acrc_pkg::ACRC_POR;
			cnt_q   <= acrc_pkg::CNT_IDLE;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ------------------------------------------------------------
	// trim loading, only ever counted from power-up
	// ------------------------------------------------------------
	// strobe resets leave trims_q alone so the window never reopens
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trims_q <= 2'h0;
		end else if (conv_end & trim_act) begin
			trims_q <= trims_q + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// result latch and outputs, all registered
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latch_q      <= acrc_pkg::DATA_RST;
			busy         <= 1'b0;
			sampling     <= 1'b0;
			trim_loading <= 1'b0;
			trim_done    <= 1'b0;
			data_out     <= acrc_pkg::DATA_RST;
			data_oe      <= acrc_pkg::DATA_RST;
		end else begin
			if (state_d == acrc_pkg::ACRC_RESET) begin
				latch_q <= acrc_pkg::DATA_RST;
			end else if (conv_end) begin
				latch_q <= result;
			end
			// busy mirrors the conversion state, dropped by reset
			busy <= (state_d == acrc_pkg::ACRC_CONV);
			if (state_d == acrc_pkg::ACRC_CONV) begin
				sampling <= 1'b0; // hold starts at the start fall
			end else if ((busy_fall & ~sel_s)
				| (sel_fall & ~in_conv)) begin
				sampling <= 1'b1;
			end
			trim_loading <= trim_act & (state_d == acrc_pkg::ACRC_CONV);
			trim_done    <= ~trim_act; // host discards until this rises
			data_out     <= latch_q;
			// one enable per bit so the pad ring stays uniform
			data_oe <= {acrc_pkg::DATA_W{~sel_s & ~rd_s}};
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	no_early_conv_a: assert property (
		(state_q == acrc_pkg::ACRC_POR) |-> !busy)
		else $error("busy during power-up reset");
	abort_reset_a: assert property (
		(in_conv & start_fall & ~sel_s) |=> state_q == acrc_pkg::ACRC_RESET)
		else $error("start during conversion did not reset");
	sel_abort_a: assert property (
		(in_conv & sel_fall) |=> state_q == acrc_pkg::ACRC_RESET)
		else $error("select fall during conversion did not reset");
	self_clear_a: assert property (
		(state_q == acrc_pkg::ACRC_RESET) |=> state_q == acrc_pkg::ACRC_IDLE)
		else $error("reset did not self clear");
	latch_zero_a: assert property (
		(state_q == acrc_pkg::ACRC_RESET) |=> data_out == acrc_pkg::DATA_RST)
		else $error("latches not cleared after reset");
	busy_drop_a: assert property (
		(state_q == acrc_pkg::ACRC_RESET) |-> !busy)
		else $error("busy high after reset");
	busy_rise_a: assert property (
		go_conv |=> busy [*8])
		else $error("busy not held through conversion");
	oe_gate_a: assert property (
		$rose(data_oe[0]) |-> $past(~sel_s & ~rd_s))
		else $error("data driven without select and read");
	trim_keep_a: assert property (
		(state_q == acrc_pkg::ACRC_RESET) |=> $stable(trims_q))
		else $error("strobe reset changed trim count");
	trim_count_a: assert property (
		trims_q <= acrc_pkg::TRIM_CONVS)
		else $error("trim count overran");

	conv_done_c: cover property (conv_end);
	abort_c: cover property (abort_req);
	trim_done_c: cover property ($rose(trim_done));
	read_c: cover property ($rose(data_oe[0]));
endmodule // acrc_core

// File: verilog/acrc_pkg.sv
package acrc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int POR_TIME_NS   = 1000;
	localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CONV_TIME_NS  = 720;
	localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] CNT_IDLE = 6'h00;
	// ------------------------------------------------------------
	// trim loading and data
	// ------------------------------------------------------------
	localparam logic [1:0] TRIM_CONVS = 2'h3;
	localparam int DATA_W = 16;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	typedef enum logic [1:0] {
		ACRC_POR, ACRC_IDLE, ACRC_CONV, ACRC_RESET
	} acrc_state_t;
endpackage

// File: verilog/acrc_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module acrc_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// first stage feeds only the second; reset level is idle high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level <= s3_q; // change counts once stages agree
			end
		end
	end
endmodule // acrc_sync

// File: verif/acrc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host model: strobes change just after a rising edge
// ------------------------------------------------------------
module acrc_host_model (
	// clock
	input  wire logic clk,
	// strobes to the device
	output logic      conversion_start_n,
	output logic      select_n,
	output logic      read_n
);
	// strobes idle high, as a released host would leave them
	initial begin
		conversion_start_n = 1'b1;
		select_n           = 1'b1;
		read_n             = 1'b1;
	end
	// advance to just after the n-th rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// four clocks low: above the minimum and seen by the pin filter
	task automatic pulse_start();
		step(1);
		conversion_start_n = 1'b0;
		step(4);
		conversion_start_n = 1'b1;
	endtask
	// select and read held long enough for the three-flop filter
	task automatic set_pins(input logic sel_n, input logic rd_n);
		step(1);
		select_n = sel_n;
		read_n   = rd_n;
		step(4);
	endtask
endmodule // acrc_host_model

// File: verif/adc_conversion_reset_control_tb.sv
`timescale 1ns/1ps
module adc_conversion_reset_control_tb;
	logic                        clk;
	logic                        rstn;
	logic                        conversion_start_n;
	logic                        select_n;
	logic                        read_n;
	logic [acrc_pkg::DATA_W-1:0] result;
	logic                        busy;
	logic                        sampling;
	logic                        trim_loading;
	logic                        trim_done;
	logic [acrc_pkg::DATA_W-1:0] data_out;
	logic [acrc_pkg::DATA_W-1:0] data_oe;
	int                          error_cnt;
	int                          total_checks;
	int                          cyc;
	acrc_core dut_u (.clk(clk), .rstn(rstn),
		.conversion_start_n(conversion_start_n), .select_n(select_n),
		.read_n(read_n), .result(result), .busy(busy),
		.sampling(sampling), .trim_loading(trim_loading),
		.trim_done(trim_done), .data_out(data_out), .data_oe(data_oe));
	acrc_host_model host_u (.clk(clk),
		.conversion_start_n(conversion_start_n), .select_n(select_n),
		.read_n(read_n));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for busy to reach a level
	task automatic wait_busy(input logic lvl, output int n);
		n = 0;
		while (busy !== lvl && n < 40) begin
			host_u.step(1);
			n++;
		end
	endtask
	// a start inside the power-up window must be ignored
	task automatic test_por();
		host_u.pulse_start();
		host_u.step(8);
		check("busy_por", busy, 16'h0);
		host_u.step(20);
		// select falls while idle: opens sampling and lets starts in
		host_u.set_pins(1'b0, 1'b1);
		host_u.step(1);
		check("sampling_sel", sampling, 16'h1);
	endtask
	// full conversion k; the first three only load trim
	task automatic do_conv(input logic [15:0] val, input int k);
		int n;
		result = val;
		fork
			host_u.pulse_start();
			wait_busy(1'b1, n);
		join
		check("busy_rise", 16'(n <= 8), 16'h1);
		check("trim_loading", trim_loading, 16'(k <= 3));
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			host_u.step(1);
			n++;
		end
		check("busy_len", 16'(n), 16'(acrc_pkg::CONV_CYCLES));
		check("sampling", sampling, 16'h1);
		host_u.step(1);
		if (k > 3)
			check("data_out", data_out, val);
		check("trim_done", trim_done, 16'(k >= 3));
	endtask
	// output enable only with select and read both low
	task automatic test_read();
		for (int i = 0; i < 4; i++) begin
			host_u.set_pins(i[1], i[0]);
			host_u.step(1); // enable is registered after the filter
			check("data_oe", data_oe, (i == 0) ? 16'hffff : 16'h0000);
		end
		host_u.set_pins(1'b0, 1'b1);
	endtask
	// abort a running conversion by start or by a select fall
	task automatic do_abort(input logic by_sel);
		int n;
		result = 16'hbeef ^ 16'(cyc);
		fork
			host_u.pulse_start();
			wait_busy(1'b1, n);
		join
		// let the start strobe rest high and the conversion run a while
		host_u.step(4);
		if (by_sel) begin
			host_u.set_pins(1'b1, 1'b1);
			host_u.set_pins(1'b0, 1'b1);
		end else
			host_u.pulse_start();
		wait_busy(1'b0, n);
		check("busy_abort", busy, 16'h0);
		check("abort_fast", 16'(n <= 8), 16'h1);
		host_u.step(2);
		check("data_clear", data_out, 16'h0000);
		check("sampling_abort", sampling, 16'h1);
		check("trim_kept", trim_done, 16'h1);
	endtask
	// hang guard: the whole sequence needs well under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		rstn = 1'b0;
		result = 16'(cyc);
		error_cnt = 0;
		total_checks = 0;
		cyc = 0;
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		test_por();
		for (int k = 1; k <= 4; k++)
			do_conv(16'h1230 + 16'(k), k);
		test_read();
		do_abort(1'b0);
		do_conv(16'h5a5a ^ 16'(cyc), 5);
		do_abort(1'b1);
		print_verdict();
	end
endmodule // adc_conversion_reset_control_tb
